// ---- dv/fppc_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module fppc_assertions
  import fppc_pkg::*;
(
  input wire logic i_ref_clk, // clock
  input wire logic i_rstn, // reset, active low
  input wire logic [11:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [31:0] o_rdata, // read data
  input wire fppc_timing_t i_tim, // timing levels
  input wire logic i_lclk_act_low, // line clock polarity
  input wire logic i_pulse_out_zero, // pulse zero level
  input wire logic i_pwr_logic, // logic power level
  input wire logic i_pwr_bias, // bias power level
  input wire logic [31:0] o_pin_out, // pad values
  input wire logic [31:0] o_pin_oe, // pad enables
  input wire logic [2:0] o_sclk_delay // shift clock delay code
);
  // ******************
  // Register shadows
  // ******************
  logic [31:0] ctl_r;
  logic [31:0] ie_r;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctl_r <= 32'h0;
      ie_r <= 32'h0;
    end else if (i_wr && i_addr == FPPC_OFS_PIN_CTL_A) begin
      ctl_r <= i_wdata & FPPC_CTL_A_MASK;
    end else if (i_wr && i_addr == FPPC_OFS_PIN_IE) begin
      ie_r <= i_wdata & FPPC_PIN_MASK;
    end
  end

  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  AST_OE_RESV: assert property ((o_pin_oe & ~FPPC_PIN_MASK) == 32'h0)
    else $error("output enable set on a reserved pad");
  AST_OE_WRITE: assert property (!ctl_r[0] && i_wr && i_addr == FPPC_OFS_PIN_OE
    ##1 !(i_wr && i_addr == FPPC_OFS_PIN_OE) |=> o_pin_oe == ($past(i_wdata, 2) & FPPC_PIN_MASK))
    else $error("pad enables differ from written mask");
  AST_SCLK_DLY: assert property (i_wr && i_addr == FPPC_OFS_PIN_CTL_A
    |=> o_sclk_delay == $past(i_wdata[26:24]))
    else $error("shift clock delay code wrong");
  AST_CTL_READ: assert property ($past(i_rd) && $past(i_addr) == FPPC_OFS_PIN_CTL_A
    |-> o_rdata == $past(ctl_r))
    else $error("control register read back wrong");
  AST_IN_GATE: assert property ($past(i_rd) && $past(i_addr) == FPPC_OFS_PIN_IN_DATA
    |-> (o_rdata & ~(ie_r | $past(ie_r) | $past(ie_r, 2))) == 32'h0)
    else $error("disabled input reads nonzero");
  AST_MOD_OFF: assert property ((!ctl_r[3]) [*3] |-> !o_pin_out[FPPC_P_MOD])
    else $error("modulation present while disabled");
  AST_MOD_SRST: assert property (i_tim.frame_start && ctl_r[23] && ctl_r[3] && !ctl_r[21]
    |-> ##[1:4] !o_pin_out[FPPC_P_MOD])
    else $error("modulation not reset at frame start");
  AST_LCLK_BLANK: assert property ((i_tim.vblank && !ctl_r[18] && !ctl_r[27] && !ctl_r[0]) [*4]
    |-> o_pin_out[FPPC_P_LCLK] == i_lclk_act_low)
    else $error("line clock not inactive in blank");
  AST_PWR_PASS: assert property ($past(i_rstn) |-> o_pin_out[1:0] == {$past(i_pwr_bias),
    $past(i_pwr_logic)} && o_pin_out[FPPC_P_PULSE_OUT_ZERO] == $past(i_pulse_out_zero))
    else $error("power or pulse pad lags its source wrongly");
endmodule : fppc_assertions

bind fppc_flat_panel_pin_control fppc_assertions fppc_assertions_i (.i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_tim(i_tim), .i_lclk_act_low(i_lclk_act_low), .i_pulse_out_zero(i_pulse_out_zero),
  .i_pwr_logic(i_pwr_logic), .i_pwr_bias(i_pwr_bias), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_sclk_delay(o_sclk_delay));
`default_nettype wire

// ---- dv/fppc_flat_panel_pin_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module fppc_flat_panel_pin_control_tb;
  import fppc_pkg::*;
  logic i_ref_clk, i_rstn, i_wr, i_rd, i_lclk_act_low, i_alt_to_pulse_out_one, i_mod_hold, vb;
  logic i_pulse_out_zero, i_pulse_out_one, i_pwr_logic, i_pwr_bias;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, i_pix, i_pin_in, o_pin_out, o_pin_oe, drv_val;
  logic [2:0] o_sclk_delay;
  logic [7:0] cyc;
  fppc_timing_t i_tim;
  int err_total, n_tests;

  fppc_flat_panel_pin_control fppc_flat_panel_pin_control_i (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_tim(i_tim), .i_lclk_act_low(i_lclk_act_low),
    .i_alt_to_pulse_out_one(i_alt_to_pulse_out_one), .i_pulse_out_zero(i_pulse_out_zero), .i_pulse_out_one(i_pulse_out_one),
    .i_pwr_logic(i_pwr_logic), .i_pwr_bias(i_pwr_bias), .i_pix(i_pix),
    .i_mod_hold(i_mod_hold), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_sclk_delay(o_sclk_delay));
  fppc_panel_model fppc_panel_model_i (.i_ref_clk(i_ref_clk), .i_pin_out(o_pin_out),
    .i_pin_oe(o_pin_oe), .i_drv_en(32'hFFFF_FFFF), .i_drv_val(drv_val), .o_pad(i_pin_in));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Free-running timing: line clock every 4 cycles, hsync every 8, vsync and frames every 16.
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 8'h1;
    i_tim <= {cyc[1], vb, cyc[2], cyc[3], 3'h0, cyc[3:0] == 4'h0, cyc[4], cyc[0]};
    i_pix <= {4{cyc}};
    {i_pulse_out_one, i_pulse_out_zero, i_pwr_bias, i_pwr_logic} <= cyc[5:2];
  end

  // ******************
  // Bus and checks
  // ******************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rdc

  task automatic cnt(input int pin, input int n, output int t);
    logic p;
    t = 0;
    p = o_pin_out[pin];
    repeat (n) begin
      tick(1);
      if (o_pin_out[pin] !== p) t++;
      p = o_pin_out[pin];
    end
  endtask : cnt

  // ******************
  // Scenarios
  // ******************
  task automatic t_regs();
    logic [11:0] ad[4] = '{FPPC_OFS_PIN_CTL_A, FPPC_OFS_PIN_OE, FPPC_OFS_PIN_IE, 12'h700};
    logic [31:0] ex[4] = '{FPPC_CTL_A_MASK, FPPC_PIN_MASK, FPPC_PIN_MASK, 32'h0};
    foreach (ad[i]) rdc(ad[i], FPPC_RST_REG);
    rdc(FPPC_OFS_PIN_IN_DATA, FPPC_RST_REG);
    foreach (ad[i]) wr(ad[i], 32'hFFFF_FFFF);
    foreach (ad[i]) rdc(ad[i], ex[i]);
    foreach (ad[i]) wr(ad[i], 32'h0);
  endtask : t_regs

  task automatic t_oe(input logic [31:0] v);
    wr(FPPC_OFS_PIN_OE, v);
    tick(1);
    chk(o_pin_oe, v & FPPC_PIN_MASK);
  endtask : t_oe

  task automatic t_in(input logic [31:0] ie, input logic [31:0] pads);
    drv_val <= pads;
    wr(FPPC_OFS_PIN_IE, ie);
    tick(3);
    rdc(FPPC_OFS_PIN_IN_DATA, ie & pads & FPPC_PIN_MASK);
  endtask : t_in

  task automatic t_lclk(input logic [31:0] ctl, input int pin, input logic act);
    int t;
    wr(FPPC_OFS_PIN_CTL_A, ctl);
    vb <= 1'b1;
    tick(8);
    cnt(pin, 32, t);
    @(posedge i_ref_clk);
    vb <= 1'b0;
    chk({31'h0, t != 0}, {31'h0, act});
    tick(8);
  endtask : t_lclk

  task automatic t_mod(input logic [31:0] stn, input logic [31:0] ctl, input logic hold,
                       input int exp);
    int t;
    wr(FPPC_OFS_PIN_CTL_A, 32'h0);
    wr(FPPC_OFS_STN_CTL, stn);
    wr(FPPC_OFS_PIN_CTL_A, ctl);
    i_mod_hold <= hold;
    tick(24);
    cnt(FPPC_P_MOD, 64, t);
    chk(32'(t), 32'(exp));
  endtask : t_mod

  task automatic results();
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    results();
  end

  initial begin
    {i_rstn, i_wr, i_rd, i_lclk_act_low, vb, i_mod_hold} = 6'h0;
    {i_pulse_out_zero, i_pulse_out_one, i_pwr_logic, i_pwr_bias} = 4'h0;
    i_alt_to_pulse_out_one = 1'b1;
    {i_addr, i_wdata, i_pix, drv_val, cyc} = '0;
    i_tim = '0;
    repeat (3) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_regs();
    for (int d = 0; d < 8; d++) begin
      wr(FPPC_OFS_PIN_CTL_A, 32'(d) << 24);
      tick(0);
      chk({29'h0, o_sclk_delay}, 32'(d));
    end
    t_oe(32'h0000_0003);
    t_oe(32'h00FC_FCFC);
    t_oe(32'h3F00_0000);
    t_oe(32'hC000_0000);
    t_oe(32'hFFFF_FFFF);
    t_oe(32'h0000_0000);
    t_in(32'h0000_0007, 32'hFFFF_FFFF);
    t_in(32'hFFFF_FFFF, 32'hA5A5_A5A5);
    t_in(32'h0000_0000, 32'hFFFF_FFFF);
    wr(FPPC_OFS_PIN_OE, 32'hFFFF_FFFF);
    t_lclk(32'h0000_0000, FPPC_P_LCLK, 1'b0);
    t_lclk(32'h0004_0000, FPPC_P_LCLK, 1'b1);
    t_lclk(32'h0800_0000, FPPC_P_LCLK, 1'b0);
    t_lclk(32'h0000_0000, FPPC_P_PULSE_OUT_ONE, 1'b0);
    t_lclk(32'h0008_0000, FPPC_P_PULSE_OUT_ONE, 1'b1);
    t_mod(32'h8100_0000, 32'h0000_0008, 1'b1, 4);
    t_mod(32'h8300_0000, 32'h0000_0008, 1'b1, 2);
    t_mod(32'h8100_0000, 32'h0010_0008, 1'b1, 4);
    t_mod(32'h0100_0000, 32'h0000_0008, 1'b1, 2);
    t_mod(32'hFF00_0000, 32'h0020_0008, 1'b1, 4);
    t_mod(32'h8100_0000, 32'h0040_0008, 1'b1, 0);
    t_mod(32'h8100_0000, 32'h0040_0008, 1'b0, 8);
    t_mod(32'hFF00_0000, 32'h0080_0008, 1'b1, 0);
    t_mod(32'h8100_0000, 32'h0000_0000, 1'b0, 0);
    results();
  end
endmodule : fppc_flat_panel_pin_control_tb
`default_nettype wire

// ---- dv/fppc_panel_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fppc_panel_model (
  input wire logic i_ref_clk, // clock
  input wire logic [31:0] i_pin_out, // device pad values
  input wire logic [31:0] i_pin_oe, // device pad enables
  input wire logic [31:0] i_drv_en, // pads the panel drives
  input wire logic [31:0] i_drv_val, // panel pad values
  output logic [31:0] o_pad // resolved pad levels
);
  // A pad nobody drives flips every cycle, so a stale value can never pass a check.
  logic [31:0] float_r = 32'h5555_5555;

  always @(posedge i_ref_clk) begin
    float_r <= ~float_r;
  end

  assign o_pad = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_drv_en & i_drv_val) |
    (~i_pin_oe & ~i_drv_en & float_r);
endmodule : fppc_panel_model
`default_nettype wire

// ---- hw/fppc_flat_panel_pin_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module fppc_flat_panel_pin_control
  import fppc_pkg::*;
(
  input wire logic i_ref_clk, // 10 MHz clock
  input wire logic i_rstn, // synchronous reset, active low
  input wire logic [11:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after strobe
  input wire fppc_timing_t i_tim, // internal panel timing levels
  input wire logic i_lclk_act_low, // line clock polarity, 1 = active low
  input wire logic i_alt_to_pulse_out_one, // route alternate line clock to pulse pin one
  input wire logic i_pulse_out_zero, // pulse generator zero level
  input wire logic i_pulse_out_one, // pulse generator one level
  input wire logic i_pwr_logic, // logic power-enable level
  input wire logic i_pwr_bias, // bias power-enable level
  input wire logic [31:0] i_pix, // panel data, used at data pin positions
  input wire logic i_mod_hold, // modulation hold signal
  input wire logic [31:0] i_pin_in, // pad input levels
  output logic [31:0] o_pin_out, // pad output values
  output logic [31:0] o_pin_oe, // pad output enables, high drives
  output logic [2:0] o_sclk_delay // shift clock pad delay code
);

  // ****************************************
  // State
  // ****************************************
  fppc_main_st_t s_r;
  fppc_main_st_t s_nxt;
  fppc_mod_cfg_t mod_cfg;
  fppc_vs_sel_t vs_sel;
  logic [31:0] pin_din;
  logic [31:0] pin_val;
  logic mod_out;
  logic lclk_fall;
  logic hs_fall;
  logic lclk_ok;
  logic alt_ok;
  logic lclk_g;
  logic alt_g;
  logic vs_pin;

  // ****************************************
  // Register access and blank tracking
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        FPPC_OFS_PIN_CTL_A: begin
          s_nxt.ctl_a = i_wdata & FPPC_CTL_A_MASK;
        end
        FPPC_OFS_PIN_OE: begin
          s_nxt.oe = i_wdata & FPPC_PIN_MASK;
        end
        FPPC_OFS_PIN_IE: begin
          s_nxt.ie = i_wdata & FPPC_PIN_MASK;
        end
        FPPC_OFS_STN_CTL: begin
          s_nxt.stn = i_wdata;
        end
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        FPPC_OFS_PIN_CTL_A: begin
          s_nxt.rdata = s_r.ctl_a;
        end
        FPPC_OFS_PIN_OE: begin
          s_nxt.rdata = s_r.oe;
        end
        FPPC_OFS_PIN_IE: begin
          s_nxt.rdata = s_r.ie;
        end
        FPPC_OFS_STN_CTL: begin
          s_nxt.rdata = s_r.stn;
        end
        FPPC_OFS_PIN_IN_DATA: begin
          s_nxt.rdata = pin_din;
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
    // The first blank line ends at the first line clock falling edge after the cycle vblank rises.
    lclk_fall = fppc_edge(i_tim.line_clk, s_r.lclk_q, 1'b1);
    hs_fall = fppc_edge(i_tim.hsync, s_r.hs_q, 1'b1);
    s_nxt.vb_q = i_tim.vblank;
    s_nxt.lclk_q = i_tim.line_clk;
    s_nxt.hs_q = i_tim.hsync;
    if (!i_tim.vblank) begin
      s_nxt.first_line = 1'b0;
    end else if (!s_r.vb_q) begin
      s_nxt.first_line = 1'b1;
    end else if (lclk_fall) begin
      s_nxt.first_line = 1'b0;
    end
    if (hs_fall) begin
      s_nxt.vs_trail = i_tim.vsync;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;

  // ****************************************
  // Line clock gating in vertical blank
  // ****************************************
  // The first blank line counts as the first line even in the cycle vblank rises, before first_line is set.
  always_comb begin
    lclk_ok = !i_tim.vblank || s_r.ctl_a[FPPC_B_LCLK_VB]
      || ((s_r.first_line || !s_r.vb_q) && s_r.ctl_a[FPPC_B_EXT_LCLK]);
    alt_ok = !i_tim.vblank || s_r.ctl_a[FPPC_B_ALT_VB]
      || ((s_r.first_line || !s_r.vb_q) && s_r.ctl_a[FPPC_B_EXT_LCLK]);
    lclk_g = lclk_ok ? i_tim.line_clk : i_lclk_act_low;
    alt_g = alt_ok ? i_tim.line_clk : i_lclk_act_low;
  end

  // ****************************************
  // Modulation generator
  // ****************************************
  always_comb begin
    mod_cfg.en = s_r.ctl_a[FPPC_B_MOD_EN];
    mod_cfg.fall_edge = s_r.ctl_a[FPPC_B_MOD_FALL];
    mod_cfg.frame_inv = s_r.ctl_a[FPPC_B_MOD_FRM_INV];
    mod_cfg.hold_mode = s_r.ctl_a[FPPC_B_MOD_HOLD];
    mod_cfg.sync_rst = s_r.ctl_a[FPPC_B_MOD_SRST];
    mod_cfg.src_hsync = s_r.stn[FPPC_B_MOD_SRC];
    mod_cfg.half_m1 = s_r.stn[FPPC_B_MOD_CNT +: 7];
  end

  fppc_mod_gen u_mod (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_cfg(mod_cfg),
    .i_vsync(i_tim.vsync),
    .i_hsync(i_tim.hsync),
    .i_frame_start(i_tim.frame_start),
    .i_hold(i_mod_hold),
    .o_mod(mod_out)
  );

  // ****************************************
  // Pin vector
  // ****************************************
  always_comb begin
    vs_sel = fppc_vs_sel_t'(s_r.ctl_a[FPPC_B_VS_SEL +: 2]);
    case (vs_sel)
      FPPC_VS_FLM: vs_pin = i_tim.first_line_marker;
      FPPC_VS_EARLY: vs_pin = i_tim.vs_early;
      FPPC_VS_LATE: vs_pin = i_tim.vs_late;
      FPPC_VS_TRAIL: vs_pin = s_r.vs_trail;
      default: vs_pin = i_tim.vsync;
    endcase
    pin_val = i_pix & FPPC_DATA_PINS;
    pin_val[FPPC_P_SCLK] = i_tim.shift_clk;
    pin_val[FPPC_P_DE] = i_tim.de;
    pin_val[FPPC_P_HS] = i_tim.hsync;
    pin_val[FPPC_P_VS] = vs_pin;
    pin_val[FPPC_P_MOD] = mod_out;
    pin_val[FPPC_P_LCLK] = lclk_g;
    // Panel-disable forces data and control pins low; power and pulse pins stay live.
    if (s_r.ctl_a[FPPC_B_PINS_OFF]) begin
      pin_val = 32'h0000_0000;
    end
    pin_val[FPPC_P_PWR_LOGIC] = i_pwr_logic;
    pin_val[FPPC_P_PWR_BIAS] = i_pwr_bias;
    pin_val[FPPC_P_PULSE_OUT_ZERO] = i_pulse_out_zero;
    pin_val[FPPC_P_PULSE_OUT_ONE] = i_alt_to_pulse_out_one ? alt_g : i_pulse_out_one;
  end

  fppc_pin_bank u_pins (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_dout(pin_val),
    .i_oe_en(s_r.oe),
    .i_ie_en(s_r.ie),
    .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe),
    .o_din(pin_din)
  );

  // The delay itself is a pad cell; this block only holds its code.
  assign o_sclk_delay = s_r.ctl_a[FPPC_B_SCLK_DLY +: 3];

endmodule : fppc_flat_panel_pin_control
`default_nettype wire

// ---- hw/fppc_mod_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module fppc_mod_gen
  import fppc_pkg::*;
(
  input wire logic i_ref_clk, // 10 MHz clock
  input wire logic i_rstn, // synchronous reset, active low
  input wire fppc_mod_cfg_t i_cfg, // modulation settings
  input wire logic i_vsync, // internal vertical sync
  input wire logic i_hsync, // internal horizontal sync
  input wire logic i_frame_start, // one-cycle frame start pulse
  input wire logic i_hold, // modulation hold signal level
  output logic o_mod // modulation output
);

  fppc_mod_st_t s_r;
  fppc_mod_st_t s_nxt;
  logic src;
  logic tick;

  always_comb begin
    s_nxt = s_r;
    src = i_cfg.src_hsync ? i_hsync : i_vsync;
    tick = fppc_edge(src, s_r.sync_q, i_cfg.fall_edge);
    s_nxt.sync_q = src;
    if (!i_cfg.en) begin
      s_nxt.mod = 1'b0;
      s_nxt.cnt = 7'h00;
    end else if (i_frame_start && i_cfg.sync_rst) begin
      s_nxt.mod = 1'b0;
      s_nxt.cnt = 7'h00;
    end else begin
      if (tick) begin
        if (i_cfg.hold_mode) begin
          if (!i_hold) begin
            s_nxt.mod = ~s_r.mod;
          end
        end else if (s_r.cnt >= i_cfg.half_m1) begin
          s_nxt.cnt = 7'h00;
          s_nxt.mod = ~s_r.mod;
        end else begin
          s_nxt.cnt = s_r.cnt + 7'h01;
        end
      end
      // A forced frame flip composes with a count flip in the same cycle.
      if (i_frame_start && i_cfg.frame_inv) begin
        s_nxt.mod = ~s_nxt.mod;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_mod = s_r.mod;

endmodule : fppc_mod_gen
`default_nettype wire

// ---- hw/fppc_pin_bank.sv ----
`timescale 1ns/100ps
`default_nettype none
module fppc_pin_bank
  import fppc_pkg::*;
(
  input wire logic i_ref_clk, // 10 MHz clock
  input wire logic i_rstn, // synchronous reset, active low
  input wire logic [31:0] i_dout, // pin values to drive
  input wire logic [31:0] i_oe_en, // output buffer enables
  input wire logic [31:0] i_ie_en, // input buffer enables
  input wire logic [31:0] i_pin_in, // pin levels seen at the pads
  output logic [31:0] o_pin_out, // registered pin values
  output logic [31:0] o_pin_oe, // registered output enables
  output logic [31:0] o_din // gated pin levels for readback
);

  fppc_pin_st_t s_r;
  fppc_pin_st_t s_nxt;

  always_comb begin
    s_nxt.dout = i_dout;
    s_nxt.oe = i_oe_en & FPPC_PIN_MASK;
    s_nxt.din = i_pin_in & i_ie_en & FPPC_PIN_MASK;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_pin_out = s_r.dout;
  assign o_pin_oe = s_r.oe;
  assign o_din = s_r.din;

endmodule : fppc_pin_bank
`default_nettype wire

// ---- hw/fppc_pkg.sv ----
package fppc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] FPPC_OFS_PIN_CTL_A = 12'h604;
  localparam logic [11:0] FPPC_OFS_PIN_OE = 12'h608;
  localparam logic [11:0] FPPC_OFS_PIN_IE = 12'h60C;
  localparam logic [11:0] FPPC_OFS_STN_CTL = 12'h610;
  localparam logic [11:0] FPPC_OFS_PIN_IN_DATA = 12'h624;
  localparam logic [31:0] FPPC_RST_REG = 32'h0000_0000;
  // Writable bits; reserved positions always read zero.
  localparam logic [31:0] FPPC_CTL_A_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] FPPC_PIN_MASK = 32'hFFFC_FCFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FPPC_B_PINS_OFF = 0;
  localparam int FPPC_B_MOD_EN = 3;
  localparam int FPPC_B_VS_SEL = 16;
  localparam int FPPC_B_LCLK_VB = 18;
  localparam int FPPC_B_ALT_VB = 19;
  localparam int FPPC_B_MOD_FALL = 20;
  localparam int FPPC_B_MOD_FRM_INV = 21;
  localparam int FPPC_B_MOD_HOLD = 22;
  localparam int FPPC_B_MOD_SRST = 23;
  localparam int FPPC_B_SCLK_DLY = 24;
  localparam int FPPC_B_EXT_LCLK = 27;
  localparam int FPPC_B_MOD_CNT = 24;
  localparam int FPPC_B_MOD_SRC = 31;
  localparam int FPPC_SCLK_DLY_MAX_NS = 7;

  // ****************************************
  // Pin positions in the pin vector
  // ****************************************
  localparam int FPPC_P_PWR_LOGIC = 0;
  localparam int FPPC_P_PWR_BIAS = 1;
  localparam int FPPC_P_SCLK = 24;
  localparam int FPPC_P_DE = 25;
  localparam int FPPC_P_HS = 26;
  localparam int FPPC_P_VS = 27;
  localparam int FPPC_P_MOD = 28;
  localparam int FPPC_P_LCLK = 29;
  localparam int FPPC_P_PULSE_OUT_ZERO = 30;
  localparam int FPPC_P_PULSE_OUT_ONE = 31;
  localparam logic [31:0] FPPC_DATA_PINS = 32'h00FC_FCFC;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {FPPC_VS_FLM, FPPC_VS_EARLY, FPPC_VS_LATE, FPPC_VS_TRAIL} fppc_vs_sel_t;

  typedef struct packed {
    logic line_clk;
    logic vblank;
    logic hsync;
    logic vsync;
    logic vs_early;
    logic vs_late;
    logic first_line_marker;
    logic frame_start;
    logic de;
    logic shift_clk;
  } fppc_timing_t;

  typedef struct packed {
    logic en;
    logic fall_edge;
    logic frame_inv;
    logic hold_mode;
    logic sync_rst;
    logic src_hsync;
    logic [6:0] half_m1;
  } fppc_mod_cfg_t;

  typedef struct packed {
    logic sync_q;
    logic [6:0] cnt;
    logic mod;
  } fppc_mod_st_t;

  typedef struct packed {
    logic [31:0] dout;
    logic [31:0] oe;
    logic [31:0] din;
  } fppc_pin_st_t;

  typedef struct packed {
    logic [31:0] ctl_a;
    logic [31:0] oe;
    logic [31:0] ie;
    logic [31:0] stn;
    logic [31:0] rdata;
    logic vb_q;
    logic first_line;
    logic lclk_q;
    logic hs_q;
    logic vs_trail;
  } fppc_main_st_t;

  function automatic logic fppc_edge(input logic now, input logic prev, input logic fall);
    fppc_edge = fall ? (prev & ~now) : (~prev & now);
  endfunction : fppc_edge

endpackage : fppc_pkg
